/* rgbdim_pkg.sv */
// Constants, codes and lookup tables shared by the LED dimming core.
// Function
// - Each channel dims by pulse width with an 8-bit duty that repeats at about 23 kHz.
// - The pulse-width counter advances on an internal 6 MHz rate, not on the host bus clock.
// - Each channel takes its duty from its own duty setting, independent of the others.
// - With ramping off, a newly written duty reaches the channel at once.
// - With ramping on and a nonzero fade time, the channel duty walks one step at a time to the newest value over the fade time.
// - A per-channel curve select chooses a linear or an exponential duty mapping.
// - One full-scale select bit picks 25.5 mA (0) or 51 mA (1) for all channels and resets to 0.
// - Each channel has an 8-bit gain code with 256 steps of the full-scale current.
// - All gain codes reset to zero, giving no current until written.
// - Channel current is full scale times gain code over 255.
// - Shutdown is entered by the shutdown command or by the bus clock line held low.
// - The fade time is a 4-bit code: 0 s, 0.05 s steps to 0.5 s, then 1, 2, 4, 6 and 8 s.
// - Configuration changes take effect only on the update command, obeyed only with chip enable set.
package rgbdim_pkg;

  // ****************************************
  // Rates and times
  // ****************************************
  localparam int CLK_HZ = 40_000_000;
  localparam int OSC_HZ = 6_000_000;
  localparam int RATE_GCD = 2_000_000;
  localparam int OSC_NUM = OSC_HZ / RATE_GCD;
  localparam int OSC_DEN = CLK_HZ / RATE_GCD;
  localparam int NUM_CH = 3;
  localparam int DUTY_STEPS = 256;
  localparam int FADE_STEP_MS = 50;
  localparam int FADE_UNIT_CYCLES = (CLK_HZ / 1000) * FADE_STEP_MS / DUTY_STEPS;
  localparam int SHUTDOWN_HOLD_MS = 100;
  localparam int SHUTDOWN_HOLD_CYCLES = (CLK_HZ / 1000) * SHUTDOWN_HOLD_MS;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0] ADDR_CHIP_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SCALE_CFG = 8'h04;
  localparam logic [7:0] ADDR_RAMP_CFG = 8'h08;
  localparam logic [7:0] ADDR_CURVE_CFG = 8'h0c;
  localparam logic [7:0] ADDR_COMMAND = 8'h10;
  localparam logic [7:0] ADDR_GAIN0 = 8'h14;
  localparam logic [7:0] ADDR_DUTY0 = 8'h20;
  localparam logic [7:0] ADDR_STATUS = 8'h2c;
  localparam logic [7:0] ADDR_STRIDE = 8'h04;
  localparam int RAMP_TIME_LSB = 4;
  localparam logic RESET_SCALE = 1'b0;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] CMD_SHUTDOWN = 8'h33;
  localparam logic [7:0] CMD_UPDATE = 8'h55;
  localparam logic [7:0] CMD_RESET = 8'hcc;
  localparam logic [7:0] CMD_WAKE = 8'h5a;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    PWR_RUN = 2'b01,
    PWR_SHUT = 2'b10
  } rgbdim_pwr_t;

  // Fade time code to a count of 50 ms units.
  function automatic logic [7:0] fade_mult(input logic [3:0] code);
    case (code)
      4'hb: return 8'h14;
      4'hc: return 8'h28;
      4'hd: return 8'h50;
      4'he: return 8'h78;
      4'hf: return 8'ha0;
      default: return {4'h0, code};
    endcase
  endfunction

endpackage

/* rgbdim_chan_if.sv */
// Signals passed between the core and one channel engine.
`timescale 1ns/1ps
`default_nettype none
interface rgbdim_chan_if;
  logic [7:0] setting;
  logic ramp_en;
  logic curve_sel;
  logic [7:0] fade_mult;
  logic unit_tick;
  logic [7:0] phase;
  logic run;
  logic pwm_on;
  logic busy;
  logic [7:0] live;
  modport top(output setting, ramp_en, curve_sel, fade_mult, unit_tick, phase, run, input pwm_on, busy, live);
  modport chan(input setting, ramp_en, curve_sel, fade_mult, unit_tick, phase, run, output pwm_on, busy, live);
endinterface
`default_nettype wire

/* rgbdim_ratediv.sv */
// Fractional rate divider giving a one-cycle enable at NUM/DEN of the clock.
`timescale 1ns/1ps
`default_nettype none
module rgbdim_ratediv #(
  parameter int NUM = 1,
  parameter int DEN = 2
) (
  input wire logic aclk,
  input wire logic aresetn,
  output logic tick
);
  localparam int W = $clog2(DEN + NUM) + 1;
  localparam logic [W-1:0] N = W'(NUM);
  localparam logic [W-1:0] D = W'(DEN);
  logic [W-1:0] acc;

  if (NUM < 1 || 2 * NUM > DEN) begin : g_chk
    $error("rate divider needs 1 <= NUM <= DEN/2");
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc <= '0;
      tick <= 1'b0;
    end else if (acc + N >= D) begin
      acc <= acc + N - D;
      tick <= 1'b1;
    end else begin
      acc <= acc + N;
      tick <= 1'b0;
    end
  end

  property p_tick_single;
    @(posedge aclk) disable iff (!aresetn) tick |=> !tick;
  endproperty
  a_tick_single: assert property (p_tick_single) else $error("rate tick longer than one cycle");
endmodule // rgbdim_ratediv
`default_nettype wire

/* rgbdim_channel.sv */
// One dimming channel: ramp toward the duty setting, curve mapping and pulse compare.
`timescale 1ns/1ps
`default_nettype none
module rgbdim_channel (
  input wire logic aclk,
  input wire logic aresetn,
  rgbdim_chan_if.chan ch
);
  logic [7:0] step_cnt;
  logic [7:0] mapped;
  logic step_fire;

  // Shift-based exponent keeps the curve monotonic without a table.
  function automatic logic [7:0] expo(input logic [7:0] x);
    logic [12:0] t;
    t = 13'({1'b1, x[4:0]}) << x[7:5];
    if (x == 8'h00) return 8'h00;
    if (x == 8'hff) return 8'hff;
    return t[12:5];
  endfunction

  assign step_fire = ch.unit_tick && (8'(step_cnt + 8'h01) >= ch.fade_mult);
  assign mapped = ch.curve_sel ? expo(ch.live) : ch.live;
  assign ch.busy = ch.ramp_en && (ch.live != ch.setting);

  always_ff @(posedge aclk) begin
    if (!aresetn || !ch.ramp_en || step_fire) begin
      step_cnt <= 8'h00;
    end else if (ch.unit_tick) begin
      step_cnt <= step_cnt + 8'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ch.live <= 8'h00;
    end else if (!ch.ramp_en || ch.fade_mult == 8'h00) begin
      ch.live <= ch.setting;
    end else if (step_fire && ch.live < ch.setting) begin
      ch.live <= ch.live + 8'h01;
    end else if (step_fire && ch.live > ch.setting) begin
      ch.live <= ch.live - 8'h01;
    end
  end

  // On while the phase is below the duty: 0 never lights, 255 lights 255 of 256 slots.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ch.pwm_on <= 1'b0;
    end else begin
      ch.pwm_on <= ch.run && (mapped > ch.phase);
    end
  end

  property p_immediate;
    @(posedge aclk) disable iff (!aresetn) !ch.ramp_en |=> ch.live == $past(ch.setting);
  endproperty
  a_immediate: assert property (p_immediate) else $error("duty not applied at once");
  property p_ramp_hold;
    @(posedge aclk) disable iff (!aresetn)
      ch.ramp_en && ch.fade_mult != 8'h00 && !step_fire && $stable(ch.ramp_en) |=> $stable(ch.live);
  endproperty
  a_ramp_hold: assert property (p_ramp_hold) else $error("ramp moved without a step");
  property p_linear;
    @(posedge aclk) disable iff (!aresetn) !ch.curve_sel |-> mapped == ch.live;
  endproperty
  a_linear: assert property (p_linear) else $error("linear curve not identity");
  property p_zero_off;
    @(posedge aclk) disable iff (!aresetn) mapped == 8'h00 |=> !ch.pwm_on;
  endproperty
  a_zero_off: assert property (p_zero_off) else $error("zero duty lit the output");
endmodule // rgbdim_channel
`default_nettype wire

/* rgbdim_core.sv */
// Three-channel LED dimming core with an AXI4-Lite register slave.
//
// Design decisions made here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module rgbdim_core #(
  parameter int ADDR_W = 8,
  parameter int FADE_UNIT_CYCLES = rgbdim_pkg::FADE_UNIT_CYCLES,
  parameter int SHUTDOWN_HOLD_CYCLES = rgbdim_pkg::SHUTDOWN_HOLD_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic bus_clock_low,
  output logic [2:0] pwm_out,
  output logic [2:0][7:0] sink_level,
  output logic full_scale_select,
  output logic shutdown_active
);

  if (ADDR_W < 6 || ADDR_W > 8 || FADE_UNIT_CYCLES < 2 || SHUTDOWN_HOLD_CYCLES < 2) begin : g_chk
    $error("rgbdim_core parameter out of range");
  end

  // ****************************************
  // Write channel
  // ****************************************
  logic [7:0] waddr;
  logic [7:0] wbyte;
  logic wlane;
  logic wr_go;
  logic wr_ok;
  logic cmd_update;
  logic cmd_shutdown;
  logic cmd_reset;
  logic cmd_wake;

  assign wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wr_ok = wr_go && wlane;
  assign cmd_update = wr_ok && waddr == rgbdim_pkg::ADDR_COMMAND && wbyte == rgbdim_pkg::CMD_UPDATE;
  assign cmd_shutdown = wr_ok && waddr == rgbdim_pkg::ADDR_COMMAND && wbyte == rgbdim_pkg::CMD_SHUTDOWN;
  assign cmd_reset = wr_ok && waddr == rgbdim_pkg::ADDR_COMMAND && wbyte == rgbdim_pkg::CMD_RESET;
  assign cmd_wake = wr_ok && waddr == rgbdim_pkg::ADDR_COMMAND && wbyte == rgbdim_pkg::CMD_WAKE;

  function automatic logic mapped_addr(input logic [7:0] a);
    return a[1:0] == 2'b00 && a <= rgbdim_pkg::ADDR_STATUS;
  endfunction

  // Address and data are caught in either order; the answer waits for both.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= rgbdim_pkg::RESP_OKAY;
      waddr <= 8'h00;
      wbyte <= 8'h00;
      wlane <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        waddr <= 8'(s_axi_awaddr);
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wbyte <= s_axi_wdata[7:0];
        wlane <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped_addr(waddr) ? rgbdim_pkg::RESP_OKAY : rgbdim_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ****************************************
  // Power state
  // ****************************************
  rgbdim_pkg::rgbdim_pwr_t pwr;
  rgbdim_pkg::rgbdim_pwr_t next_pwr;
  logic shut_by_line;
  logic [31:0] hold_cnt;
  logic line_hold_done;
  logic wake_exit;
  logic reg_init;

  assign line_hold_done = hold_cnt == 32'(SHUTDOWN_HOLD_CYCLES);
  assign wake_exit = pwr == rgbdim_pkg::PWR_SHUT && (shut_by_line ? !bus_clock_low : cmd_wake);
  // Leaving shutdown passes through initialisation, so every register returns to default.
  assign reg_init = wake_exit || cmd_reset;

  always_ff @(posedge aclk) begin
    if (!aresetn || !bus_clock_low) begin
      hold_cnt <= 32'h0;
    end else if (!line_hold_done) begin
      hold_cnt <= hold_cnt + 32'h1;
    end
  end

  always_comb begin
    next_pwr = pwr;
    case (pwr)
      rgbdim_pkg::PWR_RUN: begin
        if (cmd_shutdown || line_hold_done) begin
          next_pwr = rgbdim_pkg::PWR_SHUT;
        end
      end
      rgbdim_pkg::PWR_SHUT: begin
        if (wake_exit) begin
          next_pwr = rgbdim_pkg::PWR_RUN;
        end
      end
      default: next_pwr = rgbdim_pkg::PWR_RUN;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwr <= rgbdim_pkg::PWR_RUN;
      shut_by_line <= 1'b0;
      shutdown_active <= 1'b0;
    end else begin
      pwr <= next_pwr;
      shutdown_active <= next_pwr == rgbdim_pkg::PWR_SHUT;
      if (pwr == rgbdim_pkg::PWR_RUN) begin
        shut_by_line <= !cmd_shutdown;
      end
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  logic chip_enable;
  logic scale_stage;
  logic [7:0] ramp_stage;
  logic [7:0] ramp_active;
  logic [2:0] curve_stage;
  logic [2:0] curve_active;
  logic [2:0][7:0] gain;
  logic [2:0][7:0] duty;

  // Gain and duty apply directly; the configuration group is staged.
  always_ff @(posedge aclk) begin
    if (!aresetn || reg_init) begin
      chip_enable <= 1'b0;
      scale_stage <= rgbdim_pkg::RESET_SCALE;
      ramp_stage <= rgbdim_pkg::RESET_BYTE;
      curve_stage <= 3'h0;
      gain <= '0;
      duty <= '0;
    end else if (wr_ok) begin
      case (waddr)
        rgbdim_pkg::ADDR_CHIP_CTRL: chip_enable <= wbyte[0];
        rgbdim_pkg::ADDR_SCALE_CFG: scale_stage <= wbyte[0];
        rgbdim_pkg::ADDR_RAMP_CFG: ramp_stage <= wbyte;
        rgbdim_pkg::ADDR_CURVE_CFG: curve_stage <= wbyte[2:0];
        default: begin
        end
      endcase
      for (int i = 0; i < rgbdim_pkg::NUM_CH; i++) begin
        if (waddr == 8'(rgbdim_pkg::ADDR_GAIN0 + 8'(i) * rgbdim_pkg::ADDR_STRIDE)) begin
          gain[i] <= wbyte;
        end
        if (waddr == 8'(rgbdim_pkg::ADDR_DUTY0 + 8'(i) * rgbdim_pkg::ADDR_STRIDE)) begin
          duty[i] <= wbyte;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || reg_init) begin
      full_scale_select <= rgbdim_pkg::RESET_SCALE;
      ramp_active <= rgbdim_pkg::RESET_BYTE;
      curve_active <= 3'h0;
    end else if (cmd_update && chip_enable) begin
      full_scale_select <= scale_stage;
      ramp_active <= ramp_stage;
      curve_active <= curve_stage;
    end
  end

  // ****************************************
  // Read channel
  // ****************************************
  logic [31:0] rword;
  logic [2:0] busy;
  always_comb begin
    rword = 32'h0;
    case (8'(s_axi_araddr))
      rgbdim_pkg::ADDR_CHIP_CTRL: rword = {31'h0, chip_enable};
      rgbdim_pkg::ADDR_SCALE_CFG: rword = {31'h0, scale_stage};
      rgbdim_pkg::ADDR_RAMP_CFG: rword = {24'h0, ramp_stage};
      rgbdim_pkg::ADDR_CURVE_CFG: rword = {29'h0, curve_stage};
      rgbdim_pkg::ADDR_STATUS: rword = {26'h0, curve_active != curve_stage, full_scale_select, busy, shutdown_active};
      default: begin
        for (int i = 0; i < rgbdim_pkg::NUM_CH; i++) begin
          if (8'(s_axi_araddr) == 8'(rgbdim_pkg::ADDR_GAIN0 + 8'(i) * rgbdim_pkg::ADDR_STRIDE)) begin
            rword = {24'h0, gain[i]};
          end
          if (8'(s_axi_araddr) == 8'(rgbdim_pkg::ADDR_DUTY0 + 8'(i) * rgbdim_pkg::ADDR_STRIDE)) begin
            rword = {24'h0, duty[i]};
          end
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= rgbdim_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rword;
      s_axi_rresp <= mapped_addr(8'(s_axi_araddr)) ? rgbdim_pkg::RESP_OKAY : rgbdim_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ****************************************
  // Dimming engines
  // ****************************************
  logic osc_tick;
  logic unit_tick;
  logic [7:0] phase;

  // The 6 MHz rate is a fractional enable: its pulses jitter by one cycle, the mean is exact.
  rgbdim_ratediv #(.NUM(rgbdim_pkg::OSC_NUM), .DEN(rgbdim_pkg::OSC_DEN)) u_osc (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(osc_tick)
  );

  rgbdim_ratediv #(.NUM(1), .DEN(FADE_UNIT_CYCLES)) u_unit (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(unit_tick)
  );

  // 256 slots of the 6 MHz rate give a period of about 23.4 kHz.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase <= 8'h00;
    end else if (osc_tick) begin
      phase <= phase + 8'h01;
    end
  end

  rgbdim_chan_if ch_if[rgbdim_pkg::NUM_CH] ();

  for (genvar g = 0; g < rgbdim_pkg::NUM_CH; g++) begin : g_ch
    assign ch_if[g].setting = duty[g];
    assign ch_if[g].ramp_en = ramp_active[g];
    assign ch_if[g].curve_sel = curve_active[g];
    assign ch_if[g].fade_mult = rgbdim_pkg::fade_mult(ramp_active[rgbdim_pkg::RAMP_TIME_LSB +: 4]);
    assign ch_if[g].unit_tick = unit_tick;
    assign ch_if[g].phase = phase;
    assign ch_if[g].run = chip_enable && pwr == rgbdim_pkg::PWR_RUN;
    assign busy[g] = ch_if[g].busy;

    rgbdim_channel u_ch (
      .aclk(aclk),
      .aresetn(aresetn),
      .ch(ch_if[g])
    );

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        pwm_out[g] <= 1'b0;
        sink_level[g] <= 8'h00;
      end else begin
        pwm_out[g] <= ch_if[g].pwm_on;
        sink_level[g] <= ch_if[g].pwm_on ? gain[g] : 8'h00;
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence s_shut_cmd;
    pwr == rgbdim_pkg::PWR_RUN && cmd_shutdown;
  endsequence
  sequence s_shut_seen;
    ##1 pwr == rgbdim_pkg::PWR_SHUT ##0 shutdown_active;
  endsequence
  property p_shut_cmd;
    @(posedge aclk) disable iff (!aresetn) s_shut_cmd |-> s_shut_seen;
  endproperty
  a_shut_cmd: assert property (p_shut_cmd) else $error("shutdown command not obeyed");
  property p_line_shut;
    @(posedge aclk) disable iff (!aresetn) line_hold_done && pwr == rgbdim_pkg::PWR_RUN |=> shutdown_active;
  endproperty
  a_line_shut: assert property (p_line_shut) else $error("held clock line did not shut down");
  property p_scale_reset;
    @(posedge aclk) !aresetn |=> !full_scale_select && gain == '0;
  endproperty
  a_scale_reset: assert property (p_scale_reset) else $error("scale or gain not cleared by reset");
  property p_sink_zero;
    @(posedge aclk) !aresetn ##1 !aresetn |=> sink_level == '0;
  endproperty
  a_sink_zero: assert property (p_sink_zero) else $error("current flows after reset");
  property p_update_gated;
    @(posedge aclk) disable iff (!aresetn) cmd_update && !chip_enable && !reg_init |=> $stable(ramp_active);
  endproperty
  a_update_gated: assert property (p_update_gated) else $error("update obeyed with chip disabled");
  property p_update_apply;
    @(posedge aclk) disable iff (!aresetn)
      cmd_update && chip_enable && !reg_init |=> full_scale_select == $past(scale_stage);
  endproperty
  a_update_apply: assert property (p_update_apply) else $error("update did not apply scale");
  property p_sink;
    @(posedge aclk) disable iff (!aresetn) ch_if[0].pwm_on |=> sink_level[0] == $past(gain[0]);
  endproperty
  a_sink: assert property (p_sink) else $error("sink level not equal to gain");
  property p_phase;
    @(posedge aclk) disable iff (!aresetn) !osc_tick |=> $stable(phase);
  endproperty
  a_phase: assert property (p_phase) else $error("phase moved without the 6 MHz enable");
  property p_lut;
    @(posedge aclk) disable iff (!aresetn) ramp_active[7:4] == 4'hf |-> ch_if[0].fade_mult == 8'ha0;
  endproperty
  a_lut: assert property (p_lut) else $error("fade time code 15 is not 8 s");
endmodule // rgbdim_core
`default_nettype wire

/* rgbdim_led_model.sv */
// Behavioural LED load that tallies lit cycles and the drive level seen per channel.
`timescale 1ns/1ps
`default_nettype none
module rgbdim_led_model (
  input wire logic aclk,
  input wire logic clr,
  input wire logic [2:0] pwm_out,
  input wire logic [2:0][7:0] sink_level,
  output logic [2:0][15:0] on_cnt,
  output logic [2:0][7:0] lvl
);
  // An LED only lights on a definite high; an unknown drive is never counted as lit.
  always_ff @(posedge aclk) begin
    for (int i = 0; i < 3; i++) begin
      if (clr) begin
        on_cnt[i] <= 16'h0000;
        lvl[i] <= 8'h00;
      end else begin
        if (pwm_out[i] === 1'b1) on_cnt[i] <= on_cnt[i] + 16'h0001;
        if (sink_level[i] !== 8'h00) lvl[i] <= sink_level[i];
      end
    end
  end
endmodule // rgbdim_led_model
`default_nettype wire

/* rgb_led_dimming_core_tb.sv */
// Self-checking testbench for the three-channel LED dimming core.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin fails++; \
  $display("BAD %s exp %0h got %0h", nm, ex, got); end end
module rgb_led_dimming_core_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, fss, shut, clr = 1'b0, bcl = 1'b0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0] bresp, rresp;
  logic [2:0] pwm_out;
  logic [2:0][7:0] sink_level, lvl;
  logic [2:0][15:0] on_cnt;
  int fails = 0, compares = 0, cyc = 0;
  always #12.5 aclk = ~aclk;
  rgbdim_core #(.FADE_UNIT_CYCLES(4), .SHUTDOWN_HOLD_CYCLES(20)) dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .bus_clock_low(bcl), .pwm_out(pwm_out), .sink_level(sink_level),
    .full_scale_select(fss), .shutdown_active(shut));
  rgbdim_led_model leds (.aclk(aclk), .clr(clr), .pwm_out(pwm_out), .sink_level(sink_level),
    .on_cnt(on_cnt), .lvl(lvl));
  // ****************************************
  // Bus cycles
  // ****************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    logic [1:0] r;
    wr(a, {24'h0, d}, r);
    `CHK("bresp", rgbdim_pkg::RESP_OKAY, r)
  endtask
  // One measurement window spans two dimming periods of 256 phases at 3 phases per 20 clocks.
  task automatic measure;
    clr <= 1'b1;
    @(posedge aclk);
    clr <= 1'b0;
    repeat (3414) @(posedge aclk);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    logic [31:0] d;
    logic [1:0] r;
    rd(rgbdim_pkg::ADDR_SCALE_CFG, d, r);
    `CHK("scale_reset", 32'h0, d)
    rd(rgbdim_pkg::ADDR_GAIN0, d, r);
    `CHK("gain_reset", 32'h0, d)
    `CHK("fss_reset", 1'b0, fss)
    `CHK("sink_reset", 24'h0, sink_level)
    wr(8'h30, 32'h1, r);
    `CHK("wr_unmapped", rgbdim_pkg::RESP_SLVERR, r)
    rd(8'h31, d, r);
    `CHK("rd_unaligned", rgbdim_pkg::RESP_SLVERR, r)
    $display("done reset");
  endtask
  task automatic t_scale;
    w(rgbdim_pkg::ADDR_SCALE_CFG, 8'h01);
    w(rgbdim_pkg::ADDR_COMMAND, rgbdim_pkg::CMD_UPDATE);
    repeat (2) @(posedge aclk);
    `CHK("fss_no_enable", 1'b0, fss)
    w(rgbdim_pkg::ADDR_CHIP_CTRL, 8'h01);
    `CHK("fss_staged", 1'b0, fss)
    w(rgbdim_pkg::ADDR_COMMAND, rgbdim_pkg::CMD_UPDATE);
    repeat (2) @(posedge aclk);
    `CHK("fss_applied", 1'b1, fss)
    $display("done scale");
  endtask
  task automatic t_levels;
    for (int i = 0; i < 3; i++) begin
      w(rgbdim_pkg::ADDR_GAIN0 + 8'(4 * i), (i == 0) ? 8'h01 : (i == 1) ? 8'hff : 8'h80);
      w(rgbdim_pkg::ADDR_DUTY0 + 8'(4 * i), (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'h80);
    end
    measure();
    `CHK("duty_zero", 16'h0, on_cnt[0])
    `CHK("duty_full", 1'b1, on_cnt[1] > 16'd3380)
    `CHK("duty_half", 1'b1, on_cnt[2] > 16'd1690 && on_cnt[2] < 16'd1725)
    `CHK("gain_full", 8'hff, lvl[1])
    `CHK("gain_half", 8'h80, lvl[2])
    $display("done levels");
  endtask
  task automatic t_curve;
    w(rgbdim_pkg::ADDR_CURVE_CFG, 8'h04);
    w(rgbdim_pkg::ADDR_COMMAND, rgbdim_pkg::CMD_UPDATE);
    measure();
    `CHK("exp_mid", 1'b1, on_cnt[2] < 16'd1600)
    `CHK("lin_kept", 1'b1, on_cnt[1] > 16'd3380)
    $display("done curve");
  endtask
  task automatic t_ramp;
    logic [31:0] d;
    logic [1:0] r;
    int n;
    w(rgbdim_pkg::ADDR_RAMP_CFG, 8'h11);
    w(rgbdim_pkg::ADDR_COMMAND, rgbdim_pkg::CMD_UPDATE);
    w(rgbdim_pkg::ADDR_DUTY0, 8'h40);
    rd(rgbdim_pkg::ADDR_STATUS, d, r);
    `CHK("ramp_busy", 1'b1, d[1])
    n = 0;
    while (d[1] === 1'b1 && n < 400) begin
      rd(rgbdim_pkg::ADDR_STATUS, d, r);
      n++;
    end
    // Sixty-four steps of four cycles each take over 250 cycles, so fewer than 40 polls means no ramp.
    `CHK("ramp_long", 1'b1, n >= 40 && n < 400)
    // Code 15 waits 160 units per step, so a one-step change is still pending 300 cycles on.
    w(rgbdim_pkg::ADDR_RAMP_CFG, 8'hf1);
    w(rgbdim_pkg::ADDR_COMMAND, rgbdim_pkg::CMD_UPDATE);
    w(rgbdim_pkg::ADDR_DUTY0, 8'h41);
    repeat (300) @(posedge aclk);
    rd(rgbdim_pkg::ADDR_STATUS, d, r);
    `CHK("ramp_slow", 1'b1, d[1])
    $display("done ramp");
  endtask
  task automatic t_shut;
    logic [31:0] d;
    logic [1:0] r;
    w(rgbdim_pkg::ADDR_COMMAND, rgbdim_pkg::CMD_SHUTDOWN);
    repeat (4) @(posedge aclk);
    `CHK("cmd_shut", 1'b1, shut)
    `CHK("shut_dark", 3'b000, pwm_out)
    w(rgbdim_pkg::ADDR_COMMAND, rgbdim_pkg::CMD_WAKE);
    repeat (2) @(posedge aclk);
    `CHK("wake", 1'b0, shut)
    `CHK("wake_clear", 1'b0, fss)
    bcl <= 1'b1;
    repeat (15) @(posedge aclk);
    `CHK("line_early", 1'b0, shut)
    repeat (10) @(posedge aclk);
    `CHK("line_shut", 1'b1, shut)
    bcl <= 1'b0;
    repeat (3) @(posedge aclk);
    `CHK("line_exit", 1'b0, shut)
    w(rgbdim_pkg::ADDR_GAIN0, 8'h12);
    rd(rgbdim_pkg::ADDR_GAIN0, d, r);
    `CHK("gain_write", 32'h12, d)
    w(rgbdim_pkg::ADDR_COMMAND, rgbdim_pkg::CMD_RESET);
    rd(rgbdim_pkg::ADDR_GAIN0, d, r);
    `CHK("gain_cleared", 32'h0, d)
    $display("done shutdown");
  endtask
  task automatic conclude;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 40000) begin
      fails++;
      $display("BAD timeout exp 0 got %0d", cyc);
      conclude();
    end
  end
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_scale();
    t_levels();
    t_curve();
    t_ramp();
    t_shut();
    conclude();
  end
endmodule // rgb_led_dimming_core_tb
`default_nettype wire
